/* core/fram_array.sv */
// Byte array held in flip-flops, one write port, asynchronous read
`timescale 1ns/1ps
module fram_array
    import spi_fram_pkg::*;
#(
    parameter int ADDR_W = MEM_ADDR_W,
    parameter int DATA_W = MEM_DATA_W
)(
    input wire logic clk,
    fram_mem_if.store port
);
    logic [DATA_W-1:0] cells [2**ADDR_W];

    if (ADDR_W < 1 || ADDR_W > ADDR_FIELD_W || DATA_W != MEM_DATA_W)
    begin : g_check
        $error("fram_array: unsupported geometry");
    end

    // Completes within the byte time, no busy period
    always_ff @(posedge clk)
    begin
        if (port.we)
        begin
            cells[port.addr] <= port.wrData;
        end
    end

    assign port.rdData = cells[port.addr];
endmodule : fram_array

/* core/fram_mem_if.sv */
// Port between the serial front end and the byte array
`timescale 1ns/1ps
interface fram_mem_if #(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 8
);
    logic [ADDR_W-1:0] addr;
    logic we;
    logic [DATA_W-1:0] wrData;
    logic [DATA_W-1:0] rdData;
    modport ctrl(output addr, output we, output wrData, input rdData);
    modport store(input addr, input we, input wrData, output rdData);
endinterface : fram_mem_if

/* core/spi_fram_pkg.sv */
// Shared constants and types for the serial memory slave front end
package spi_fram_pkg;
    localparam int MEM_ADDR_W = 13;
    localparam int MEM_DATA_W = 8;
    localparam int ADDR_FIELD_W = 16;
    localparam int SHIFT_W = ADDR_FIELD_W - 1;

    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;

    localparam int SR_PROTECT = 7;
    localparam int SR_WEL = 1;
    localparam int SR_ZERO = 0;
    localparam logic [7:0] SR_WR_MASK = 8'hFC;
    localparam logic [7:0] SR_RESET = 8'h00;

    localparam int PIN_CS = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_SI = 2;
    localparam int PIN_HOLD = 3;
    localparam int PIN_WP = 4;
    localparam int PIN_N = 5;
    localparam logic [PIN_N-1:0] PIN_RESET = 5'h19;

    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_STEP = 4'h1;
    localparam logic [3:0] LAST_BYTE_BIT = 4'h7;
    localparam logic [3:0] LAST_ADDR_BIT = 4'hF;

    typedef enum logic [2:0] {
        ST_CMD = 3'b000,
        ST_RADDR = 3'b001,
        ST_WADDR = 3'b010,
        ST_RDATA = 3'b011,
        ST_WDATA = 3'b100,
        ST_SRR = 3'b101,
        ST_SRW = 3'b110,
        ST_IGNORE = 3'b111
    } phase_t;
endpackage : spi_fram_pkg

/* core/spi_fram_slave_front_end.sv */
// Serial slave front end of a byte-wide nonvolatile memory
//
// Behaviour
// - Select high: standby, output released, all other pins ignored.
// - Select low: device active and takes part in transfers.
// - Undriven select reads as inactive high; csN has no pull-up here, only reset loads the sampled select high.
// - Pause low: transfer suspended, output released, clock and data ignored.
// - Serial input is captured on clock rising edges.
// - Serial output changes on clock falling edges.
// - Clock modes 0 and 3 both work; no others.
// - Device is only a slave; master provides clock and select.
// - Input carries command, then address, then write data.
// - Output returns array data or status, per command.
// - Array holds 8192 bytes, byte addressed.
// - Writes finish at serial speed; next command may follow at once.
// - Status writes allowed by write-protect pin and protect-enable bit.
// - Each command opens with an 8-bit code, MSB first.
// - Select rising mid-code discards the partial command.
`timescale 1ns/1ps
module spi_fram_slave_front_end
    import spi_fram_pkg::*;
#(
    parameter int ADDR_W = MEM_ADDR_W
)(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic csN,
    input wire logic sck,
    input wire logic si,
    input wire logic holdN,
    input wire logic wpN,
    output logic soOut,
    output logic soOe
);
    if (ADDR_W < 1 || ADDR_W > ADDR_FIELD_W)
    begin : g_check
        $error("spi_fram_slave_front_end: ADDR_W out of range");
    end

    logic [PIN_N-1:0] pinRaw;
    logic [PIN_N-1:0] pinF;
    logic csF;
    logic sckF;
    logic siF;
    logic holdF;
    logic wpF;
    logic csPrev;
    logic sckPrev;
    logic active;
    logic sckRise;
    logic sckFall;
    logic csRise;
    phase_t state;
    logic [3:0] bitCnt;
    logic [SHIFT_W-1:0] shiftReg;
    logic [ADDR_W-1:0] addr;
    logic wel;
    logic cmdWrite;
    logic [7:0] statusReg;
    logic [7:0] statusByte;
    logic [7:0] inByte;
    logic [ADDR_FIELD_W-1:0] addrWord;
    logic lastBit;
    logic byteEnd;
    logic cmdDone;
    logic addrEnd;
    logic srDone;
    logic srAllowed;
    logic outState;
    logic needLoad;
    logic [7:0] outShift;
    logic outArmed;

    fram_mem_if #(.ADDR_W(ADDR_W), .DATA_W(MEM_DATA_W)) mem ();

    fram_array #(.ADDR_W(ADDR_W), .DATA_W(MEM_DATA_W)) u_array (
        .clk(clk),
        .port(mem)
    );

    assign pinRaw = {wpN, holdN, si, sck, csN};

    // Three-stage sampling; a change counts once stages two and three agree
    for (genvar i = 0; i < PIN_N; i++)
    begin : g_sync
        logic s1;
        logic s2;
        logic s3;
        logic f;
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                s1 <= PIN_RESET[i];
                s2 <= PIN_RESET[i];
                s3 <= PIN_RESET[i];
                f <= PIN_RESET[i];
            end
            else
            begin
                s1 <= pinRaw[i];
                s2 <= s1;
                s3 <= s2;
                if (s2 == s3)
                begin
                    f <= s3;
                end
            end
        end
        assign pinF[i] = f;
    end

    assign csF = pinF[PIN_CS];
    assign sckF = pinF[PIN_SCK];
    assign siF = pinF[PIN_SI];
    assign holdF = pinF[PIN_HOLD];
    assign wpF = pinF[PIN_WP];

    // Edges only count while selected and not paused
    assign active = !csF && holdF;
    assign sckRise = active && sckF && !sckPrev;
    assign sckFall = active && !sckF && sckPrev;
    assign csRise = csF && !csPrev;

    assign inByte = {shiftReg[6:0], siF};
    assign addrWord = {shiftReg, siF};
    assign lastBit = bitCnt == LAST_BYTE_BIT;
    assign byteEnd = sckRise && lastBit;
    assign cmdDone = byteEnd && state == ST_CMD;
    assign addrEnd = sckRise && bitCnt == LAST_ADDR_BIT &&
        (state == ST_RADDR || state == ST_WADDR);
    assign srDone = byteEnd && state == ST_SRW;
    assign srAllowed = wel && !(statusReg[SR_PROTECT] && !wpF);
    assign statusByte = {statusReg[SR_PROTECT:SR_WEL+1], wel, 1'b0};
    assign outState = state == ST_RDATA || state == ST_SRR;

    assign mem.addr = addr;
    assign mem.we = byteEnd && state == ST_WDATA && wel;
    assign mem.wrData = inByte;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            csPrev <= 1'b1;
            sckPrev <= 1'b0;
        end
        else
        begin
            csPrev <= csF;
            sckPrev <= sckF; // Tracked while idle so mode 3 start has no edge
        end
    end

    // Command sequencing
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= ST_CMD;
        end
        else if (csF)
        begin
            state <= ST_CMD;
        end
        else if (sckRise)
        begin
            case (state)
                ST_CMD:
                begin
                    if (lastBit)
                    begin
                        case (inByte)
                            OP_RDSR: state <= ST_SRR;
                            OP_WRSR: state <= ST_SRW;
                            OP_READ: state <= ST_RADDR;
                            OP_WRITE: state <= ST_WADDR;
                            default: state <= ST_IGNORE;
                        endcase
                    end
                end
                ST_RADDR:
                begin
                    if (addrEnd)
                    begin
                        state <= ST_RDATA;
                    end
                end
                ST_WADDR:
                begin
                    if (addrEnd)
                    begin
                        state <= ST_WDATA;
                    end
                end
                ST_SRW:
                begin
                    if (lastBit)
                    begin
                        state <= ST_IGNORE;
                    end
                end
                default: state <= state;
            endcase
        end
    end

    // Bit position; frozen during a pause
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bitCnt <= BIT_ZERO;
        end
        else if (csF)
        begin
            bitCnt <= BIT_ZERO;
        end
        else if (sckRise)
        begin
            if (lastBit && state != ST_RADDR && state != ST_WADDR)
            begin
                bitCnt <= BIT_ZERO;
            end
            else if (addrEnd)
            begin
                bitCnt <= BIT_ZERO;
            end
            else
            begin
                bitCnt <= bitCnt + BIT_STEP;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            shiftReg <= '0;
        end
        else if (sckRise)
        begin
            shiftReg <= {shiftReg[SHIFT_W-2:0], siF};
        end
    end

    // Address load and auto-increment with rollover
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            addr <= '0;
        end
        else if (addrEnd)
        begin
            addr <= addrWord[ADDR_W-1:0];
        end
        else if (byteEnd && (state == ST_RDATA || state == ST_WDATA))
        begin
            addr <= addr + ADDR_W'(1);
        end
    end

    // Write enable latch
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wel <= 1'b0;
            cmdWrite <= 1'b0;
        end
        else if (csRise)
        begin
            cmdWrite <= 1'b0;
            if (cmdWrite)
            begin
                wel <= 1'b0;
            end
        end
        else if (cmdDone)
        begin
            cmdWrite <= inByte == OP_WRITE || inByte == OP_WRSR;
            if (inByte == OP_WREN)
            begin
                wel <= 1'b1;
            end
            else if (inByte == OP_WRDI)
            begin
                wel <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            statusReg <= SR_RESET;
        end
        else if (srDone && srAllowed)
        begin
            statusReg <= (inByte & SR_WR_MASK) |
                (statusReg & ~SR_WR_MASK);
        end
    end

    // Output byte: status at once, array data one cycle after the address
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            needLoad <= 1'b0;
            outShift <= '0;
        end
        else
        begin
            needLoad <= (addrEnd && state == ST_RADDR) ||
                (byteEnd && state == ST_RDATA);
            if (needLoad)
            begin
                outShift <= mem.rdData;
            end
            else if ((cmdDone && inByte == OP_RDSR) ||
                (byteEnd && state == ST_SRR))
            begin
                outShift <= statusByte;
            end
            else if (sckFall && outState)
            begin
                outShift <= {outShift[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            soOut <= 1'b0;
            outArmed <= 1'b0;
        end
        else if (csF)
        begin
            outArmed <= 1'b0;
        end
        else if (sckFall && outState)
        begin
            soOut <= outShift[7];
            outArmed <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            soOe <= 1'b0;
        end
        else
        begin
            soOe <= active && (outArmed || (sckFall && outState));
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_standby_so_off: assert property (csF |=> !soOe)
        else $error("output driven while deselected");
    a_standby_restart: assert property (
        csF |=> (state == ST_CMD && bitCnt == BIT_ZERO))
        else $error("sequence not restarted while deselected");
    a_selected_counts: assert property (
        sckRise |=> bitCnt != $past(bitCnt))
        else $error("selected clock edge not counted");
    a_pause_so_off: assert property (!holdF |=> !soOe)
        else $error("output driven during pause");
    a_pause_freeze: assert property (
        !holdF |=> ($stable(bitCnt) && $stable(shiftReg)))
        else $error("position moved during pause");
    a_capture_rise: assert property (
        sckRise |=> shiftReg[0] == $past(siF))
        else $error("input not captured on rising edge");
    a_drive_fall: assert property (
        !$stable(soOut) |-> $past(sckFall))
        else $error("output changed off a falling edge");
    a_wren_latch: assert property (
        cmdDone && inByte == OP_WREN |=> wel)
        else $error("enable command not taken");
    a_partial_drop: assert property (
        csRise && state == ST_CMD |=> $stable(wel) && $stable(statusReg))
        else $error("partial command had an effect");
    a_status_guard: assert property (
        srDone && !srAllowed |=> $stable(statusReg))
        else $error("protected status written");
    a_wel_clear: assert property (csRise && cmdWrite |=> !wel)
        else $error("latch kept after write command");
    a_write_step: assert property (
        mem.we |=> addr == ADDR_W'($past(addr) + ADDR_W'(1)))
        else $error("address not stepped after write");

    c_read_byte: cover property (byteEnd && state == ST_RDATA);
    c_mode3_start: cover property ($fell(csF) && sckF);
    c_pause_mid: cover property (!holdF && outArmed && !csF);
    c_status_write: cover property (srDone && srAllowed);
endmodule : spi_fram_slave_front_end

/* dv/spi_fram_slave_front_end_tb.sv */
// Self-checking bench for the serial memory slave front end
`timescale 1ns/1ps
module spi_fram_slave_front_end_tb
    import spi_fram_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic csN, sck, si, holdN, wpN, soOut, soOe;
    int mismatches = 0;
    int totalChecks = 0;
    logic [7:0] rx [4];
    logic [7:0] junk;

    always #4 clk = ~clk;

    spi_fram_slave_front_end spi_fram_slave_front_end_inst (
        .clk(clk), .arst_n(arst_n), .csN(csN), .sck(sck), .si(si),
        .holdN(holdN), .wpN(wpN), .soOut(soOut), .soOe(soOe));

    spi_master_model spi_master_model_inst (
        .clk(clk), .csN(csN), .sck(sck), .si(si), .holdN(holdN),
        .wpN(wpN), .soOut(soOut), .soOe(soOe));

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        totalChecks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    // One whole frame: opcode, optional address, data bytes
    task automatic run(input logic [7:0] op, input logic [15:0] a = 16'h0,
                       input bit hasA = 1'b0, input int n = 0,
                       input logic [31:0] wd = 32'h0);
        spi_master_model_inst.sel();
        spi_master_model_inst.xbyte(op, junk);
        if (hasA)
        begin
            spi_master_model_inst.xbyte(a[15:8], junk);
            spi_master_model_inst.xbyte(a[7:0], junk);
        end
        for (int i = 0; i < n; i++)
            spi_master_model_inst.xbyte(wd[31 - 8 * i -: 8], rx[i]);
        spi_master_model_inst.desel();
    endtask : run

    task automatic t_standby();
        for (int i = 0; i < 8; i++)
        begin
            spi_master_model_inst.bitx(OP_WREN[7 - i], junk[0]);
            check({7'h00, spi_master_model_inst.seenOe}, 8'h00, "oe");
        end
        run(OP_RDSR, 16'h0, 1'b0, 1);
        check(rx[0], 8'h00, "deselected opcode");
        $display("test standby done");
    endtask : t_standby

    task automatic t_rw();
        run(OP_WREN);
        run(OP_WRITE, 16'hFFFF, 1'b1, 2, 32'hA53C_0000);
        run(OP_READ, 16'h1FFF, 1'b1, 2);
        check(rx[0], 8'hA5, "top byte");
        check(rx[1], 8'h3C, "wrapped byte");
        check({7'h00, spi_master_model_inst.seenOe}, 8'h01, "oe");
        $display("test mode0 done");
    endtask : t_rw

    task automatic t_mode3();
        spi_master_model_inst.mode3 = 1'b1;
        run(OP_WREN);
        run(OP_WRITE, 16'h0123, 1'b1, 1, 32'h5A00_0000);
        run(OP_READ, 16'hE123, 1'b1, 1);
        check(rx[0], 8'h5A, "mode 3 read");
        spi_master_model_inst.mode3 = 1'b0;
        $display("test mode3 done");
    endtask : t_mode3

    task automatic t_status();
        run(OP_WRITE, 16'h0123, 1'b1, 1, 32'hC300_0000);
        run(OP_READ, 16'h0123, 1'b1, 1);
        check(rx[0], 8'h5A, "unlatched write");
        run(OP_WREN);
        run(OP_RDSR, 16'h0, 1'b0, 2);
        check(rx[0], 8'h02, "latch set");
        check(rx[1], 8'h02, "status repeat");
        run(OP_WRSR, 16'h0, 1'b0, 1, 32'h8F00_0000);
        run(OP_RDSR, 16'h0, 1'b0, 1);
        check(rx[0], 8'h8C, "status write");
        spi_master_model_inst.pins(1'b0, 1'b1);
        run(OP_WREN);
        run(OP_WRSR, 16'h0, 1'b0, 1, 32'h0);
        run(OP_RDSR, 16'h0, 1'b0, 1);
        check(rx[0], 8'h8C, "protected");
        spi_master_model_inst.pins(1'b1, 1'b1);
        run(OP_WREN);
        run(OP_WRSR, 16'h0, 1'b0, 1, 32'h0);
        run(OP_RDSR, 16'h0, 1'b0, 1);
        check(rx[0], 8'h00, "unprotected");
        $display("test status done");
    endtask : t_status

    task automatic t_partial();
        run(OP_WREN);
        run(OP_WRDI);
        run(OP_RDSR, 16'h0, 1'b0, 1);
        check(rx[0], 8'h00, "latch cleared");
        spi_master_model_inst.sel();
        for (int i = 7; i >= 4; i--)
            spi_master_model_inst.bitx(OP_WREN[i], junk[0]);
        spi_master_model_inst.desel();
        run(OP_RDSR, 16'h0, 1'b0, 1);
        check(rx[0], 8'h00, "partial opcode");
        $display("test partial done");
    endtask : t_partial

    task automatic t_pause();
        run(OP_WREN);
        run(OP_WRITE, 16'h0040, 1'b1, 1, 32'h9600_0000);
        spi_master_model_inst.sel();
        spi_master_model_inst.xbyte(OP_READ, junk);
        spi_master_model_inst.xbyte(8'h00, junk);
        spi_master_model_inst.xbyte(8'h40, junk);
        for (int i = 7; i >= 0; i--)
        begin
            if (i == 4)
            begin
                spi_master_model_inst.pins(1'b1, 1'b0);
                repeat (8) @(posedge clk);
                check({7'h00, soOe}, 8'h00, "pause oe");
                spi_master_model_inst.bitx(1'b1, junk[0]);
                spi_master_model_inst.bitx(1'b0, junk[0]);
                spi_master_model_inst.pins(1'b1, 1'b1);
                repeat (10) @(posedge clk);
                check({7'h00, soOe}, 8'h01, "resume oe");
            end
            spi_master_model_inst.bitx(1'b0, junk[i]);
        end
        spi_master_model_inst.desel();
        check(junk, 8'h96, "resumed byte");
        $display("test pause done");
    endtask : t_pause

    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        t_standby();
        t_rw();
        t_mode3();
        t_status();
        t_partial();
        t_pause();
        print_verdict();
    end

    initial
    begin
        repeat (100000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
endmodule : spi_fram_slave_front_end_tb

/* dv/spi_master_model.sv */
// Serial master model driving the memory front end pins
`timescale 1ns/1ps
module spi_master_model (
    input wire logic clk,
    output logic csN,
    output logic sck,
    output logic si,
    output logic holdN,
    output logic wpN,
    input wire logic soOut,
    input wire logic soOe
);
    logic mode3 = 1'b0;
    logic seenOe = 1'b0;

    initial
    begin
        csN = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        holdN = 1'b1;
        wpN = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic pins(input logic wp, input logic hold);
        tick(1);
        wpN <= wp;
        holdN <= hold;
    endtask : pins

    // Idle clock level set first, then select
    task automatic sel();
        tick(1);
        sck <= mode3;
        tick(4);
        csN <= 1'b0;
        tick(6);
    endtask : sel

    task automatic desel();
        tick(10);
        sck <= mode3;
        tick(4);
        csN <= 1'b1;
        // Released data line no longer shows its last value
        si <= ~si;
        tick(6);
    endtask : desel

    // One bit: fall and drive, then rise and sample
    task automatic bitx(input logic b, output logic r);
        tick(1);
        sck <= 1'b0;
        si <= b;
        tick(10);
        sck <= 1'b1;
        // Shared data line: shows the master's bit unless the slave drives
        r = soOe ? soOut : si;
        seenOe = soOe;
        tick(10);
    endtask : bitx

    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
            bitx(tx[i], rx[i]);
    endtask : xbyte
endmodule : spi_master_model
